//--- pkg/lsbb_consts.vh
`ifndef LSBB_CONSTS_VH
`define LSBB_CONSTS_VH

// ==========================================
// instruction word layout
`define LSBB_INSTR_W 14
`define LSBB_PC_W 15
`define LSBB_FADDR_W 7
`define LSBB_DEST_BIT 7
`define LSBB_BIT_LSB 7
`define LSBB_BIT_MSB 9

// ==========================================
// opcode fields and values
`define LSBB_OPC6_AND_LITERAL 6'h39
`define LSBB_OPC6_AND_FILE 6'h05
`define LSBB_OPC6_ASR 6'h37
`define LSBB_OPC4_BIT_CLEAR 4'h4
`define LSBB_OPC4_BIT_SET 4'h5
`define LSBB_OPC4_TEST_SKIP_CLR 4'h6
`define LSBB_OPC5_BRANCH_LIT 5'h19
`define LSBB_ENC_BRANCH_WREG 14'h000B
`define LSBB_ENC_NO_OPERATION 14'h0000

// ==========================================
// reset values
`define LSBB_PC_RST 15'h0000
`define LSBB_WREG_RST 8'h00

`endif

//--- rtl/lsbb_file_ram.v
`timescale 1ns/1ps
`include "lsbb_consts.vh"

module lsbb_file_ram (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [`LSBB_FADDR_W-1:0] addr_i,
   input wire we_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o
);
   reg [7:0] mem [0:(1<<`LSBB_FADDR_W)-1];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // read data registered so the consumer sees it one edge after the address
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= mem[addr_i];
      end
   end
endmodule

//--- rtl/lsbb_exec.v
// What this block does
// - and_literal_op ANDs W with 8-bit literal, result to W, only Z changes.
// - and_file_op ANDs W with file register 0..127, only Z changes.
// - destination bit 0 writes W, destination bit 1 writes the file register.
// - shift right keeps bit 7, bits 7:1 go to 6:0, bit 0 to carry.
// - bit_clear_op forces selected bit 0..7 of file register to zero.
// - bit_set_op forces selected bit 0..7 of file register to one.
// - literal branch loads incremented PC plus sign-extended 9-bit offset.
// - literal branch takes two instruction cycles.
// - register branch adds unsigned W to incremented PC, two instruction cycles.
// - skip-if-clear discards next instruction when bit is 0, as a no_operation.
// - skip-if-clear lets next instruction run when the tested bit is 1.
// - PC-changing or true-test instructions take two cycles, second a no_operation.
`timescale 1ns/1ps
`include "lsbb_consts.vh"

module lsbb_exec (
   input wire clk_i,
   input wire sys_rst_i,
   input wire instr_valid_i,
   input wire [`LSBB_INSTR_W-1:0] instr_i,
   output wire instr_ready_o,
   output reg [`LSBB_PC_W-1:0] pc_o,
   output reg pc_load_o,
   output reg [7:0] wreg_o,
   output reg carry_o,
   output reg zero_o,
   output reg retire_o,
   output reg discard_o
);
   // ==========================================
   // sequencer and latched instruction
   localparam [1:0] ST_FETCH = 2'h0;
   localparam [1:0] ST_EXEC = 2'h1;
   // two idle states stretch a branch to a second instruction cycle
   localparam [1:0] ST_IDLE_A = 2'h2;
   localparam [1:0] ST_IDLE_B = 2'h3;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`LSBB_INSTR_W-1:0] ir_r;
   reg skip_r;

   wire [`LSBB_FADDR_W-1:0] faddr = ir_r[`LSBB_FADDR_W-1:0];
   wire dest_file = ir_r[`LSBB_DEST_BIT];
   wire [2:0] bsel = ir_r[`LSBB_BIT_MSB:`LSBB_BIT_LSB];
   wire [7:0] bmask;

   // one compare per bit instead of a shifter
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bmask
         assign bmask[gi] = {29'h0, bsel} == gi;
      end
   endgenerate

   wire is_and_lit = ir_r[13:8] == `LSBB_OPC6_AND_LITERAL;
   wire is_and_file = ir_r[13:8] == `LSBB_OPC6_AND_FILE;
   wire is_asr = ir_r[13:8] == `LSBB_OPC6_ASR;
   wire is_bclr = ir_r[13:10] == `LSBB_OPC4_BIT_CLEAR;
   wire is_bset = ir_r[13:10] == `LSBB_OPC4_BIT_SET;
   wire is_tsc = ir_r[13:10] == `LSBB_OPC4_TEST_SKIP_CLR;
   wire is_br_lit = ir_r[13:9] == `LSBB_OPC5_BRANCH_LIT;
   // the register branch is one full-word encoding, no operand field
   wire is_br_wreg = ir_r == `LSBB_ENC_BRANCH_WREG;

   wire accept = (state_r == ST_FETCH) && instr_valid_i;
   wire in_exec = state_r == ST_EXEC;
   // a discarded slot behaves as no_operation
   wire live = in_exec && !skip_r;

   // words are refused through execute and the branch idle states
   assign instr_ready_o = state_r == ST_FETCH;

   // ==========================================
   // file register storage
   wire [7:0] fdata;
   reg [7:0] fwdata;
   reg fwe;

   lsbb_file_ram u_ram (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .addr_i(in_exec ? faddr : instr_i[`LSBB_FADDR_W-1:0]),
      .we_i(fwe),
      .wdata_i(fwdata),
      .rdata_o(fdata)
   );

   // ==========================================
   // datapath
   wire [7:0] and_lit_res = wreg_o & ir_r[7:0];
   wire [7:0] and_file_res = wreg_o & fdata;
   wire [7:0] asr_res = {fdata[7], fdata[7:1]};
   // targets wrap within the counter width
   wire [`LSBB_PC_W-1:0] pc_one = {{(`LSBB_PC_W-1){1'b0}}, 1'b1};
   wire [`LSBB_PC_W-1:0] br_lit_off = {{(`LSBB_PC_W-9){ir_r[8]}}, ir_r[8:0]};
   wire [`LSBB_PC_W-1:0] br_wreg_off = {{(`LSBB_PC_W-8){1'b0}}, wreg_o};
   wire tsc_taken = !fdata[bsel];
   wire take_branch = live && (is_br_lit || is_br_wreg);

   always @* begin
      fwe = 1'b0;
      fwdata = fdata;
      if (live) begin
         if (is_and_file && dest_file) begin
            fwe = 1'b1;
            fwdata = and_file_res;
         end else if (is_asr && dest_file) begin
            fwe = 1'b1;
            fwdata = asr_res;
         end else if (is_bclr) begin
            fwe = 1'b1;
            fwdata = fdata & ~bmask;
         end else if (is_bset) begin
            fwe = 1'b1;
            fwdata = fdata | bmask;
         end
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_FETCH: begin
            if (instr_valid_i) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // branches spend a full extra instruction cycle idle
            state_nxt = take_branch ? ST_IDLE_A : ST_FETCH;
         end
         ST_IDLE_A: begin
            state_nxt = ST_IDLE_B;
         end
         ST_IDLE_B: begin
            state_nxt = ST_FETCH;
         end
         default: begin
            state_nxt = ST_FETCH;
         end
      endcase
   end

   // ==========================================
   // sequencer state and latched instruction
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_FETCH;
         ir_r <= `LSBB_ENC_NO_OPERATION;
         skip_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (accept) begin
            ir_r <= instr_i;
         end
         // a pending skip is spent by the very next taken word
         if (in_exec) begin
            skip_r <= live && is_tsc && tsc_taken;
         end
      end
   end

   // ==========================================
   // program counter
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pc_o <= `LSBB_PC_RST;
         pc_load_o <= 1'b0;
      end else begin
         pc_load_o <= 1'b0;
         if (accept) begin
            // counter already points past this word when it executes
            pc_o <= pc_o + pc_one;
         end
         // accept and live never meet: fetch and execute are distinct states
         if (live && is_br_lit) begin
            pc_o <= pc_o + br_lit_off;
            pc_load_o <= 1'b1;
         end else if (live && is_br_wreg) begin
            pc_o <= pc_o + br_wreg_off;
            pc_load_o <= 1'b1;
         end
      end
   end

   // ==========================================
   // working register and status flags
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wreg_o <= `LSBB_WREG_RST;
         carry_o <= 1'b0;
         zero_o <= 1'b0;
      end else if (live) begin
         if (is_and_lit) begin
            wreg_o <= and_lit_res;
            zero_o <= and_lit_res == 8'h00;
         end else if (is_and_file) begin
            if (!dest_file) begin
               wreg_o <= and_file_res;
            end
            zero_o <= and_file_res == 8'h00;
         end else if (is_asr) begin
            if (!dest_file) begin
               wreg_o <= asr_res;
            end
            carry_o <= fdata[0];
            zero_o <= asr_res == 8'h00;
         end
      end
   end

   // ==========================================
   // retire pulses
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         retire_o <= 1'b0;
         discard_o <= 1'b0;
      end else begin
         retire_o <= in_exec;
         discard_o <= in_exec && skip_r;
      end
   end
endmodule

//--- dv/lsbb_exec_sva.sv
`timescale 1ns/1ps
`include "lsbb_consts.vh"
module lsbb_exec_sva (
   input wire clk_i,
   input wire sys_rst_i,
   input wire instr_valid_i,
   input wire [`LSBB_INSTR_W-1:0] instr_i,
   input wire instr_ready_o,
   input wire [`LSBB_PC_W-1:0] pc_o,
   input wire pc_load_o,
   input wire [7:0] wreg_o,
   input wire carry_o,
   input wire zero_o,
   input wire retire_o,
   input wire discard_o
);
   // ==========================================
   // helpers
   wire tk = instr_valid_i & instr_ready_o;
   wire [`LSBB_PC_W-1:0] off = {{6{instr_i[8]}}, instr_i[8:0]};
   wire [7:0] lit = instr_i[7:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================
   // properties
   take_stall_a: assert property (tk |=> !instr_ready_o) else $error("ready held after take");
   retire_lat_a: assert property (tk |-> ##2 retire_o) else $error("retire late");
   pc_step_a: assert property (tk |=> pc_o == $past(pc_o) + 15'h0001) else $error("pc not stepped");
   branch_idle_a: assert property (pc_load_o |-> !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o)
      else $error("branch idle cycles wrong");
   lit_target_a: assert property (tk && instr_i[13:9] == `LSBB_OPC5_BRANCH_LIT |-> ##2 discard_o ||
      (pc_load_o && pc_o == $past(pc_o, 2) + 15'h0001 + $past(off, 2))) else $error("literal branch target");
   wreg_target_a: assert property (tk && instr_i == `LSBB_ENC_BRANCH_WREG |-> ##2 discard_o ||
      (pc_load_o && pc_o == $past(pc_o, 2) + 15'h0001 + {7'h00, $past(wreg_o, 2)})) else $error("wreg branch");
   and_lit_a: assert property (tk && instr_i[13:8] == `LSBB_OPC6_AND_LITERAL |-> ##2 discard_o ||
      (wreg_o == ($past(wreg_o, 2) & $past(lit, 2)) && zero_o == (wreg_o == 8'h00))) else $error("and literal");
   bit_flags_a: assert property (tk && instr_i[13:12] == 2'h1 |=> $stable({zero_o, carry_o}) [*2])
      else $error("flags moved on bit op");
   discard_pair_a: assert property (discard_o |-> retire_o && !pc_load_o) else $error("discard alone");
endmodule
bind lsbb_exec lsbb_exec_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .wreg_o(wreg_o),
   .carry_o(carry_o), .zero_o(zero_o), .retire_o(retire_o), .discard_o(discard_o));

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "lsbb_consts.vh"
module tb_top;
   reg clk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg instr_valid_i = 1'b0;
   reg [13:0] instr_i = 14'h0000;
   wire instr_ready_o, pc_load_o, carry_o, zero_o, retire_o, discard_o;
   wire [14:0] pc_o;
   wire [7:0] wreg_o;
   reg [7:0] mem_m [0:127];
   reg [7:0] w_m = 8'h00;
   reg [14:0] pc_m = 15'h0000;
   reg c_m = 1'b0, z_m = 1'b0, skip_m = 1'b0, dsc_m = 1'b0, ld_m = 1'b0;
   reg [31:0] s = 32'h297;
   reg [31:0] x;
   reg [6:0] a;
   integer error_cnt = 0;
   integer checks_done = 0;
   integer i, j;
   always #5 clk_i = ~clk_i;
   lsbb_exec DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .instr_ready_o(instr_ready_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .wreg_o(wreg_o), .carry_o(carry_o),
      .zero_o(zero_o), .retire_o(retire_o), .discard_o(discard_o));
   // ==========================================
   // helpers
   function [31:0] rnd;
      input integer d;
      begin
         s = s ^ (s << 13);
         s = s ^ (s >> 17);
         s = s ^ (s << 5);
         rnd = s;
      end
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_wreg(input [7:0] got, input [7:0] exp);
      begin
         chk({8'h00, got}, {8'h00, exp});
      end
   endtask
   task chk_flags(input [1:0] got, input [1:0] exp);
      begin
         chk({14'h0000, got}, {14'h0000, exp});
      end
   endtask
   task chk_pc(input [14:0] got, input [14:0] exp);
      begin
         chk({1'b0, got}, {1'b0, exp});
      end
   endtask
   task chk_pulses(input [2:0] got, input [2:0] exp);
      begin
         chk({13'h0000, got}, {13'h0000, exp});
      end
   endtask
   task complete_run;
      begin
         $display("errors %0d checks %0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task model(input [13:0] w);
      reg [6:0] f;
      reg [2:0] b;
      reg [7:0] v;
      begin
         f = w[6:0];
         b = w[9:7];
         v = mem_m[f];
         pc_m = pc_m + 15'h0001;
         ld_m = 1'b0;
         dsc_m = skip_m;
         skip_m = 1'b0;
         if (dsc_m) ;
         else if (w[13:8] == `LSBB_OPC6_AND_LITERAL) w_m = w_m & w[7:0];
         else if (w[13:8] == `LSBB_OPC6_AND_FILE || w[13:8] == `LSBB_OPC6_ASR) begin
            if (w[13:8] == `LSBB_OPC6_ASR) begin
               c_m = v[0];
               v = {v[7], v[7:1]};
            end
            else v = v & w_m;
            z_m = (v == 8'h00);
            if (w[`LSBB_DEST_BIT]) mem_m[f] = v;
            else w_m = v;
         end
         else if (w[13:10] == `LSBB_OPC4_BIT_CLEAR) mem_m[f][b] = 1'b0;
         else if (w[13:10] == `LSBB_OPC4_BIT_SET) mem_m[f][b] = 1'b1;
         else if (w[13:10] == `LSBB_OPC4_TEST_SKIP_CLR) skip_m = !v[b];
         else if (w[13:9] == `LSBB_OPC5_BRANCH_LIT) {ld_m, pc_m} = {1'b1, pc_m + {{6{w[8]}}, w[8:0]}};
         else if (w == `LSBB_ENC_BRANCH_WREG) {ld_m, pc_m} = {1'b1, pc_m + {7'h00, w_m}};
         if (!dsc_m && w[13:8] == `LSBB_OPC6_AND_LITERAL) z_m = (w_m == 8'h00);
      end
   endtask
   // offered at a falling edge; the next word can follow at once, two clocks after the take
   task run(input [13:0] w);
      integer n;
      begin
         instr_valid_i = 1'b1;
         instr_i = w;
         n = 0;
         while (instr_ready_o !== 1'b1) begin
            @(negedge clk_i);
            n = n + 1;
            if (n > 20) begin
               error_cnt = error_cnt + 1;
               complete_run;
            end
         end
         @(negedge clk_i);
         instr_valid_i = 1'b0;
         model(w);
         @(negedge clk_i);
         chk_wreg(wreg_o, w_m);
         chk_flags({zero_o, carry_o}, {z_m, c_m});
         chk_pc(pc_o, pc_m);
         chk_pulses({retire_o, discard_o, pc_load_o}, {1'b1, dsc_m, ld_m});
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      chk({wreg_o, zero_o, carry_o, instr_ready_o, retire_o}, 12'h002);
      // file registers power up unknown, so every address used is built bit by bit first
      for (i = 0; i < 8; i = i + 1) begin
         for (j = 0; j < 8; j = j + 1) begin
            x = rnd(0);
            run({3'h2, x[0], j[2:0], {5{i[2]}}, i[1:0]});
         end
      end
      run({`LSBB_OPC5_BRANCH_LIT, 9'h100});
      run({`LSBB_OPC5_BRANCH_LIT, 9'h0FF});
      for (i = 0; i < 400; i = i + 1) begin
         x = rnd(0);
         a = {{5{x[5]}}, x[4:3]};
         case (x[2:0])
            3'h0: run({`LSBB_OPC6_AND_LITERAL, x[15:8]});
            3'h1: run({`LSBB_OPC6_AND_FILE, x[6], a});
            3'h2: run({`LSBB_OPC6_ASR, x[6], a});
            3'h3: run({`LSBB_OPC4_BIT_CLEAR, x[9:7], a});
            3'h4: run({`LSBB_OPC4_BIT_SET, x[9:7], a});
            3'h5: run({`LSBB_OPC4_TEST_SKIP_CLR, x[9:7], a});
            3'h6: run({`LSBB_OPC5_BRANCH_LIT, x[16:8]});
            default: run(`LSBB_ENC_BRANCH_WREG);
         endcase
      end
      complete_run;
   end
endmodule
